// ==== core/dma_decode_pkg.sv ====
// shared constants, types and access map for the dma arbiter and register decoder
package dma_decode_pkg;

    localparam int NUM_CHAN = 7;
    localparam int CHAN_W = 3;
    // channel index doubles as priority: lower index wins
    localparam logic [CHAN_W-1:0] CH_EXPBUS = 3'h0;
    localparam logic [CHAN_W-1:0] CH_VIDEO = 3'h1;
    localparam logic [CHAN_W-1:0] CH_SOUND = 3'h2;
    localparam logic [CHAN_W-1:0] CH_TELECOM = 3'h3;
    localparam logic [CHAN_W-1:0] CH_HIGHWAY = 3'h4;
    localparam logic [CHAN_W-1:0] CH_UART_A = 3'h5;
    localparam logic [CHAN_W-1:0] CH_UART_B = 3'h6;

    localparam logic [2:0] VIDEO_BURST = 3'h4;
    localparam logic [2:0] SINGLE_BURST = 3'h1;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [3:0] BE_LANE0 = 4'h1;
    localparam int FIFO_DEPTH = 8;

    localparam logic [31:0] FUNC_BASE = 32'h10C00000;
    localparam logic [9:0] OFF_TEST = 10'h1C8;
    localparam logic [31:0] TEST_RESET = 32'h00000000;
    localparam int TEST_EN_BIT = 7;
    localparam int TEST_NOTIME_BIT = 6;
    localparam int TEST_FORCE_LSB = 0;
    localparam int TEST_FORCE_W = 6;
    localparam int TEST_USED_W = 8;

    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dma_chan_t;

    typedef struct packed {
        logic cs;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [31:0] data;
    } rd_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_DRAIN = 2'b10
    } arb_state_t;

    // returns {readable, writable} for a word aligned offset
    function automatic logic [1:0] reg_access(input logic [9:0] off);
        logic [1:0] acc;
        acc = 2'b00;
        if (off inside {[10'h000:10'h010], 10'h028, [10'h074:10'h084], 10'h090, 10'h0A0, 10'h0B0,
                        10'h0C4, 10'h0C8, 10'h0DC, 10'h0E0, 10'h0F8, [10'h100:10'h110],
                        [10'h118:10'h12C], [10'h148:10'h154], 10'h160, 10'h164, [10'h180:10'h188],
                        [10'h190:10'h198], [10'h1C0:10'h1C8], 10'h1D8, 10'h1DC, 10'h1F0, 10'h1FC})
            acc = 2'b11;
        else if (off inside {[10'h014:10'h020], [10'h02C:10'h070], 10'h0A4, 10'h0A8,
                             [10'h0B4:10'h0BC], [10'h0CC:10'h0D4], [10'h0E4:10'h0EC], 10'h0F4,
                             [10'h1E0:10'h1EC], 10'h1F4, 10'h1F8})
            acc = 2'b01;
        else if (off inside {10'h088, 10'h08C, 10'h0C0, 10'h0D8, 10'h0F0, 10'h114, 10'h140, 10'h144,
                             10'h18C, 10'h208})
            acc = 2'b10;
        return acc;
    endfunction

endpackage

// ==== core/dma_and_decode_unit.sv ====
// seven channel dma arbiter with read-data fifo, plus function register address decoder
`timescale 1ns/1ps

// ****************************************
// read data fifo
// ****************************************
module rd_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_o = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + AW'(1);
            end
            if (pop)
            begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // rd_fifo

// ****************************************
// arbiter, sequencer and decoder
// ****************************************
module dma_and_decode_unit
    import dma_decode_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire dma_chan_t chan_i [NUM_CHAN],
    output logic [NUM_CHAN-1:0] ack_o,
    output logic [31:0] rd_data_o,
    input wire logic rd_ready_i,
    output logic start_o,
    output logic mem_write_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    output logic [3:0] mem_be_o,
    input wire logic mem_done_i,
    input wire logic [31:0] mem_rdata_i,
    input wire reg_req_t reg_i,
    output logic [255:0] reg_we_o,
    output logic [255:0] reg_re_o,
    output logic [31:0] reg_rdata_o,
    output logic [31:0] reg_wdata_o
);
    arb_state_t state_q;
    logic [NUM_CHAN-1:0] pend_q;
    logic [NUM_CHAN-1:0] live_req;
    logic [NUM_CHAN-1:0] ack_q;
    logic [CHAN_W-1:0] sel_q;
    logic [CHAN_W-1:0] win;
    logic win_ok;
    logic [2:0] left_q;
    logic start_q;
    logic mem_write_q;
    logic [31:0] mem_addr_q;
    logic [31:0] mem_wdata_q;
    logic [3:0] mem_be_q;
    logic [31:0] rd_data_q;
    logic [31:0] test_q;
    logic [31:0] reg_rdata_q;
    logic [31:0] reg_wdata_q;
    logic [255:0] we_q;
    logic [255:0] re_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    rd_word_t fifo_out;
    rd_word_t fifo_in;
    logic [31:0] reg_off;
    logic [1:0] acc;
    logic grant;
    logic [NUM_CHAN-1:0] busy_mask;

    // ****************************************
    // request qualification and priority
    // ****************************************
    always_comb
    begin
        for (int c = 0; c < NUM_CHAN; c++)
        begin
            live_req[c] = chan_i[c].req;
        end
        // video may only write to memory; its read requests are dropped
        live_req[CH_VIDEO] = chan_i[CH_VIDEO].req && chan_i[CH_VIDEO].write;
        // test forcing, never set in the field
        if (test_q[TEST_EN_BIT])
        begin
            live_req[TEST_FORCE_W-1:0] = live_req[TEST_FORCE_W-1:0]
                                       | test_q[TEST_FORCE_LSB +: TEST_FORCE_W];
        end
    end

    always_comb
    begin
        win = CH_UART_B;
        win_ok = 1'b0;
        // scan low priority first so the highest pending wins last
        for (int c = NUM_CHAN - 1; c >= 0; c--)
        begin
            if (pend_q[c] || live_req[c])
            begin
                win = CHAN_W'(c);
                win_ok = 1'b1;
            end
        end
    end

    // a read grant needs fifo room, since done from memory cannot be refused
    assign grant = (state_q == ST_IDLE) && win_ok
                && (chan_i[win].write || fifo_in_ready);
    assign busy_mask = (state_q != ST_IDLE) ? (NUM_CHAN'(1) << sel_q) : '0;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_q <= '0;
        end
        else
        begin
            // the channel in service still holds its request; latching it would serve it twice
            pend_q <= (pend_q | (live_req & ~busy_mask)) & ~(grant ? (NUM_CHAN'(1) << win) : '0);
        end
    end

    // ****************************************
    // transaction sequencer
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            sel_q <= '0;
            left_q <= '0;
            start_q <= 1'b0;
            mem_write_q <= 1'b0;
            mem_addr_q <= '0;
            mem_be_q <= '0;
        end
        else
        begin
            start_q <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (grant)
                    begin
                        state_q <= ST_XFER;
                        sel_q <= win;
                        start_q <= 1'b1;
                        mem_write_q <= chan_i[win].write;
                        mem_addr_q <= chan_i[win].addr;
                        left_q <= (win == CH_VIDEO) ? VIDEO_BURST : SINGLE_BURST;
                        if (win == CH_UART_A || win == CH_UART_B)
                        begin
                            mem_be_q <= BE_LANE0 << chan_i[win].addr[1:0];
                        end
                        else
                        begin
                            mem_be_q <= BE_ALL;
                        end
                    end
                end
                ST_XFER:
                begin
                    if (mem_done_i)
                    begin
                        left_q <= left_q - 3'h1;
                        if (left_q == 3'h1)
                        begin
                            state_q <= mem_write_q ? ST_IDLE : ST_DRAIN;
                        end
                    end
                end
                ST_DRAIN:
                begin
                    // read ends once its word has left the fifo
                    if (!fifo_out_valid)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // write data follows the winner so each burst word is fresh after its ack
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mem_wdata_q <= '0;
        end
        else
        begin
            mem_wdata_q <= grant ? chan_i[win].wdata : chan_i[sel_q].wdata;
        end
    end

    // ****************************************
    // read data buffer and acknowledges
    // ****************************************
    assign fifo_in.chan = sel_q;
    assign fifo_in.data = mem_rdata_i;
    assign fifo_pop = fifo_out_valid && rd_ready_i;

    rd_fifo #(
        .WIDTH($bits(rd_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(state_q == ST_XFER && mem_done_i && !mem_write_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rd_ready_i),
        .out_data_o(fifo_out)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= '0;
            rd_data_q <= '0;
        end
        else
        begin
            ack_q <= '0;
            // write: ack per word done, one per video beat
            if (state_q == ST_XFER && mem_done_i && mem_write_q)
            begin
                ack_q <= NUM_CHAN'(1) << sel_q;
            end
            // read: ack with data as the word leaves the fifo
            if (fifo_pop)
            begin
                ack_q <= NUM_CHAN'(1) << fifo_out.chan;
                rd_data_q <= fifo_out.data;
            end
        end
    end

    // ****************************************
    // function register decoder
    // ****************************************
    assign reg_off = reg_i.addr - FUNC_BASE;
    assign acc = (reg_off[31:10] == '0 && reg_off[1:0] == 2'h0) ? reg_access(reg_off[9:0]) : 2'b00;

    generate
        for (genvar i = 0; i < 256; i++)
        begin : g_enable
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    we_q[i] <= 1'b0;
                    re_q[i] <= 1'b0;
                end
                else
                begin
                    // unmapped or wrong-direction accesses yield no pulse
                    we_q[i] <= reg_i.cs && reg_i.write && acc[0] && reg_off[9:2] == 8'(i);
                    re_q[i] <= reg_i.cs && !reg_i.write && acc[1] && reg_off[9:2] == 8'(i);
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            test_q <= TEST_RESET;
            reg_rdata_q <= '0;
            reg_wdata_q <= '0;
        end
        else
        begin
            reg_wdata_q <= reg_i.wdata;
            if (reg_i.cs && reg_i.write && reg_off[31:0] == 32'(OFF_TEST))
            begin
                test_q <= {24'h000000, reg_i.wdata[TEST_USED_W-1:0]};
            end
            reg_rdata_q <= '0;
            if (reg_i.cs && !reg_i.write && reg_off[31:0] == 32'(OFF_TEST))
            begin
                reg_rdata_q <= test_q;
            end
        end
    end

    assign ack_o = ack_q;
    assign rd_data_o = rd_data_q;
    assign start_o = start_q;
    assign mem_write_o = mem_write_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign mem_be_o = mem_be_q;
    assign reg_we_o = we_q;
    assign reg_re_o = re_q;
    assign reg_rdata_o = reg_rdata_q;
    assign reg_wdata_o = reg_wdata_q;
endmodule // dma_and_decode_unit

// ==== dv/dma_and_decode_unit_checker.sv ====
// port-level assertions for the dma arbiter and register decoder
`timescale 1ns/1ps
module dma_and_decode_unit_checker
    import dma_decode_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire dma_chan_t chan_i [NUM_CHAN],
    input wire logic [NUM_CHAN-1:0] ack_o,
    input wire logic [31:0] rd_data_o,
    input wire logic rd_ready_i,
    input wire logic start_o,
    input wire logic mem_write_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic [3:0] mem_be_o,
    input wire logic mem_done_i,
    input wire logic [31:0] mem_rdata_i,
    input wire reg_req_t reg_i,
    input wire logic [255:0] reg_we_o,
    input wire logic [255:0] reg_re_o,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [31:0] reg_wdata_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet2;
        !start_o [*2];
    endsequence
    property p_start_gap;
        start_o |=> s_quiet2;
    endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("start pulses too close");
    property p_addr_held;
        start_o |=> $stable(mem_addr_o) && $stable(mem_be_o);
    endproperty
    a_addr_held: assert property (p_addr_held)
        else $error("memory address moved in transfer");
    property p_ack_onehot;
        $onehot0(ack_o);
    endproperty
    a_ack_onehot: assert property (p_ack_onehot)
        else $error("two channels acknowledged");
    property p_uart_lane;
        start_o && mem_be_o != BE_ALL |-> $onehot(mem_be_o);
    endproperty
    a_uart_lane: assert property (p_uart_lane)
        else $error("byte lane not one-hot");
    property p_write_ack;
        mem_done_i && mem_write_o |=> ack_o != '0;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("no ack after write word");
    property p_one_pulse;
        $onehot0(reg_we_o | reg_re_o);
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("more than one enable pulse");
    property p_test_we;
        reg_i.cs && reg_i.write && reg_i.addr == FUNC_BASE + {22'h0, OFF_TEST} |=> reg_we_o[OFF_TEST[9:2]];
    endproperty
    a_test_we: assert property (p_test_we)
        else $error("test register write pulse missing");
    property p_wo_read;
        reg_i.cs && !reg_i.write && reg_i.addr == FUNC_BASE + 32'h14 |=> reg_re_o == '0;
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("read pulse on write-only offset");
    property p_idle_quiet;
        !reg_i.cs |=> (reg_we_o | reg_re_o) == '0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("pulse without chip select");
    property p_wdata_align;
        reg_we_o != '0 |-> reg_wdata_o == $past(reg_i.wdata);
    endproperty
    a_wdata_align: assert property (p_wdata_align)
        else $error("write data not aligned to pulse");
endmodule // dma_and_decode_unit_checker

bind dma_and_decode_unit dma_and_decode_unit_checker chk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .chan_i(chan_i),
    .ack_o(ack_o),
    .rd_data_o(rd_data_o),
    .rd_ready_i(rd_ready_i),
    .start_o(start_o),
    .mem_write_o(mem_write_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_be_o(mem_be_o),
    .mem_done_i(mem_done_i),
    .mem_rdata_i(mem_rdata_i),
    .reg_i(reg_i),
    .reg_we_o(reg_we_o),
    .reg_re_o(reg_re_o),
    .reg_rdata_o(reg_rdata_o),
    .reg_wdata_o(reg_wdata_o)
);

// ==== dv/mem_side_model.sv ====
// memory subsystem model: answers each transaction with done pulses
`timescale 1ns/1ps
module mem_side_model (
    input wire logic core_clk_i,
    input wire logic start_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] beats_i,
    input wire logic [3:0] wait_i,
    output logic done_o,
    output logic [31:0] rdata_o
);
    initial
    begin
        done_o = 1'b0;
        rdata_o = 32'h0;
    end
    // one word per done; burst length comes from the bench
    always
    begin
        @(posedge core_clk_i);
        if (start_i === 1'b1)
        begin
            for (int b = 0; b < beats_i; b++)
            begin
                if (wait_i != 4'h0)
                begin
                    // released bus shows the inverse, not a stale match
                    done_o <= 1'b0;
                    rdata_o <= ~(addr_i ^ 32'(b));
                    repeat (wait_i) @(posedge core_clk_i);
                end
                done_o <= 1'b1;
                rdata_o <= addr_i ^ 32'(b);
                @(posedge core_clk_i);
            end
            // done drops at burst end, and also before each beat when wait_i is nonzero; never twice in one step
            done_o <= 1'b0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // mem_side_model

// ==== dv/dma_and_decode_unit_bench.sv ====
// self-checking bench for the dma arbiter and register decoder
`timescale 1ns/1ps
module dma_and_decode_unit_bench
    import dma_decode_pkg::*;
;
    logic core_clk_i, rst_n_i, rd_ready_i, start_o, mem_write_o, mem_done_i;
    dma_chan_t chan_i [NUM_CHAN];
    dma_chan_t src [NUM_CHAN];
    logic [NUM_CHAN-1:0] want, ack_o;
    logic [31:0] rd_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i, reg_rdata_o, reg_wdata_o;
    logic [3:0] mem_be_o, lat;
    reg_req_t reg_i;
    logic [255:0] reg_we_o, reg_re_o;
    logic [2:0] beats;
    int err_count, num_checks, n_start;
    int ack_log[$];

    dma_and_decode_unit uut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .chan_i(chan_i),
        .ack_o(ack_o),
        .rd_data_o(rd_data_o),
        .rd_ready_i(rd_ready_i),
        .start_o(start_o),
        .mem_write_o(mem_write_o),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_be_o(mem_be_o),
        .mem_done_i(mem_done_i),
        .mem_rdata_i(mem_rdata_i),
        .reg_i(reg_i),
        .reg_we_o(reg_we_o),
        .reg_re_o(reg_re_o),
        .reg_rdata_o(reg_rdata_o),
        .reg_wdata_o(reg_wdata_o)
    );
    mem_side_model mem (.core_clk_i(core_clk_i), .start_i(start_o), .addr_i(mem_addr_o), .beats_i(beats),
        .wait_i(lat), .done_o(mem_done_i), .rdata_o(mem_rdata_i));
    assign beats = (mem_addr_o[7:4] == 4'h1) ? VIDEO_BURST : SINGLE_BURST;

    // ****************************************
    // sources, monitor and helpers
    // ****************************************
    // a source drops its request in the ack cycle, else it would be served again
    always_comb
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            chan_i[i] = src[i];
            chan_i[i].req = want[i] & ~ack_o[i];
        end
    always @(posedge core_clk_i)
    begin
        if (start_o === 1'b1)
            n_start++;
        for (int i = 0; i < NUM_CHAN; i++)
            if (ack_o[i] === 1'b1)
            begin
                ack_log.push_back(i);
                want[i] <= 1'b0;
            end
    end
    function automatic logic [31:0] base(input int i);
        return 32'h20000000 + 32'(i * 16);
    endfunction
    task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic reg_acc(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_i <= {1'b1, wr, a, d};
        @(posedge core_clk_i);
        reg_i.cs <= 1'b0;
        #1;
    endtask
    task automatic req(input int ch, input logic wr, input logic [31:0] a);
        @(posedge core_clk_i);
        src[ch] <= {1'b0, wr, a, ~a};
        want[ch] <= 1'b1;
    endtask
    task automatic wait_acks(input int n);
        for (int t = 0; t < 400 && ack_log.size() < n; t++)
            @(posedge core_clk_i);
        chk("ack count", n, ack_log.size());
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        reg_acc(FUNC_BASE + 32'h1C8, 1'b0, 32'h0);
        chk("start_o", 0, start_o);
        chk("test reg", TEST_RESET, reg_rdata_o);
        $display("reset test done");
    endtask
    task automatic t_prio;
        int exp[$] = '{0, 1, 1, 1, 1, 2, 3, 4, 5, 6};
        int n0;
        n0 = n_start;
        ack_log.delete();
        for (int i = 0; i < NUM_CHAN; i++)
            req(i, 1'b1, base(i));
        wait_acks(10);
        for (int k = 0; k < 10; k++)
            chk("ack order", exp[k], ack_log[k]);
        chk("start count", 7, n_start - n0);
        $display("priority test done");
    endtask
    task automatic t_uart_lane;
        int ch;
        logic [31:0] wd;
        for (int k = 0; k < 4; k++)
        begin
            ch = 5 + k % 2;
            wd = ~(base(ch) + 32'(k));
            ack_log.delete();
            req(ch, k[1], base(ch) + 32'(k));
            wait_acks(1);
            chk("uart lane", BE_LANE0 << k, mem_be_o);
            chk("mem addr", base(ch) + 32'(k), mem_addr_o);
            if (k[1])
                chk("mem wdata", wd, mem_wdata_o);
        end
        $display("uart lane test done");
    endtask
    task automatic t_read_stall;
        ack_log.delete();
        rd_ready_i <= 1'b0;
        lat <= 4'h3;
        req(3, 1'b0, base(3));
        repeat (20) @(posedge core_clk_i);
        chk("ack while stalled", 0, ack_log.size());
        rd_ready_i <= 1'b1;
        wait_acks(1);
        chk("read data", base(3), rd_data_o);
        chk("direction", 0, mem_write_o);
        $display("read stall test done");
    endtask
    task automatic t_video_read;
        int n0;
        n0 = n_start;
        req(1, 1'b0, base(1));
        repeat (20) @(posedge core_clk_i);
        chk("video read starts", n0, n_start);
        want[1] <= 1'b0;
        $display("video direction test done");
    endtask
    task automatic t_decode;
        int off[12] = '{'h1C8, 'h1C8, 'h014, 'h014, 'h088, 'h088, 'h100, 'h100, 'h024, 'h1CA, 'h400, 'h208};
        bit wr[12] = '{1, 0, 1, 0, 0, 1, 1, 0, 1, 1, 1, 0};
        bit hit[12] = '{1, 1, 1, 0, 1, 0, 1, 1, 0, 0, 0, 1};
        logic [255:0] oh;
        for (int k = 0; k < 12; k++)
        begin
            // bit 7 stays clear: forcing requests is for production test only
            reg_acc(FUNC_BASE + 32'(off[k]), wr[k], 32'hFFFFFF45);
            oh = hit[k] ? 256'h1 << (off[k] >> 2) : '0;
            chk("write pulse", wr[k] ? oh : '0, reg_we_o);
            chk("read pulse", wr[k] ? '0 : oh, reg_re_o);
            if (k == 1)
                chk("test reg", 32'h45, reg_rdata_o);
        end
        $display("decode test done");
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        err_count++;
        $display("[ERR] watchdog exp finish got hang");
        tally_and_finish;
    end
    initial
    begin
        rst_n_i = 1'b0;
        rd_ready_i = 1'b1;
        reg_i = '0;
        want = '0;
        lat = 4'h0;
        foreach (src[i]) src[i] = '0;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_prio;
        t_uart_lane;
        t_read_stall;
        t_video_read;
        t_decode;
        tally_and_finish;
    end
endmodule // dma_and_decode_unit_bench
